// File: core/virtual_concat_inverse_mux.sv
/*
  concatenation group end point: source splitter, member tagging,
  sink alignment and reassembly, axi4-lite register file, interrupt.
  assumes member streams and payload share aclk; the network may
  reorder members freely and skew them up to the skew setting.
*/
`timescale 1ns/100ps
`include "vcat_regs.svh"

module virtual_concat_inverse_mux #(
  parameter int MAX_MEMBERS = `VC_MAX_MEMBERS,
  parameter int DEPTH = `VC_DEPTH,
  parameter int IW = $clog2(MAX_MEMBERS),
  parameter int CW = $clog2(MAX_MEMBERS + 1),
  parameter int SW = $clog2(DEPTH),
  parameter int MW = `VC_MFI_W
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [`VC_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [`VC_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // source payload in
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  // source member streams out
  output logic [7:0] tx_out_data,
  output logic [IW-1:0] tx_out_seq,
  output logic [7:0] tx_out_container,
  output logic [MW-1:0] tx_out_mfi,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  // sink member streams in
  input wire logic [7:0] rx_in_data,
  input wire logic [IW-1:0] rx_in_seq,
  input wire logic [MW-1:0] rx_in_mfi,
  input wire logic rx_in_valid,
  // sink payload out
  output logic [7:0] rx_out_data,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  // status
  output logic group_halted,
  output logic irq
);
  typedef struct packed {
    logic active;
    vcat_pkg::member_type_t cfg_type;
    logic [CW-1:0] cfg_members;
    logic [7:0] cfg_maxdly;
    logic sw_enable;
    logic [2:0] sw_type;
    logic [CW-1:0] sw_members;
    logic [7:0] sw_maxdly;
    logic [IW-1:0] map_idx;
    logic [MAX_MEMBERS-1:0][7:0] map;
    logic [`VC_IRQ_W-1:0] irq_status;
    logic [`VC_IRQ_W-1:0] irq_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [IW-1:0] tx_seq;
    logic [7:0] tx_container;
    logic [MW-1:0] tx_mfi;
    logic [IW-1:0] tx_idx;
    logic [MW-1:0] tx_frame;
    vcat_pkg::rx_state_t rx_state;
    logic [MW-1:0] rd_mfi;
    logic [IW-1:0] rd_idx;
    logic out_valid;
    logic [7:0] out_data;
    logic halted;
  } state_t;

  state_t st;
  state_t n;
  logic wr_go;
  logic ar_go;
  logic tx_take;
  logic rx_take;
  logic bad_seq;
  logic late;
  logic buf_wr;
  logic clr_en;
  logic flush;
  logic [MW-1:0] diff;
  logic [IW-1:0] tx_last;
  logic [IW-1:0] rd_last;
  logic [7:0] buf_rd_data;
  logic [CW-1:0] slot_count;
  logic [31:0] group_bw;
  logic [32:0] wr_cur;
  logic [32:0] rd_cur;
  logic [31:0] wd;
  logic [`VC_IRQ_W-1:0] set_mask;

  function automatic logic [17:0] member_rate(
      input vcat_pkg::member_type_t t);
    unique case (t)
      vcat_pkg::mt_vc11: return `VC_RATE_VC11;
      vcat_pkg::mt_vc12: return `VC_RATE_VC12;
      vcat_pkg::mt_vt3: return `VC_RATE_VT3;
      vcat_pkg::mt_vc2: return `VC_RATE_VC2;
      vcat_pkg::mt_vc3: return `VC_RATE_VC3;
      vcat_pkg::mt_vc4: return `VC_RATE_VC4;
    endcase
  endfunction : member_rate

  function automatic logic [CW-1:0] member_limit(
      input vcat_pkg::member_type_t t);
    logic [8:0] l;
    l = (t == vcat_pkg::mt_vc3 || t == vcat_pkg::mt_vc4) ?
        `VC_LIMIT_HO : `VC_LIMIT_LO;
    return (int'(l) > MAX_MEMBERS) ? CW'(MAX_MEMBERS) : CW'(l);
  endfunction : member_limit

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  // returns {hit, value}
  function automatic logic [32:0] reg_read(
      input logic [`VC_ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      `VC_OFF_CTRL: begin
        v[`VC_CTRL_EN_BIT] = st.sw_enable;
        v[`VC_CTRL_TYPE_LSB +: 3] = st.sw_type;
      end
      `VC_OFF_MEMBERS: v[CW-1:0] = st.sw_members;
      `VC_OFF_MAXDLY: v[7:0] = st.sw_maxdly;
      `VC_OFF_MAPIDX: v[IW-1:0] = st.map_idx;
      `VC_OFF_MAPVAL: v[7:0] = st.map[st.map_idx];
      `VC_OFF_IRQ_STATUS: v[`VC_IRQ_W-1:0] = st.irq_status;
      `VC_OFF_IRQ_EN: v[`VC_IRQ_W-1:0] = st.irq_en;
      `VC_OFF_IRQ_CLR: v = '0;
      `VC_OFF_STATE: begin
        v[`VC_STATE_ACTIVE_BIT] = st.active;
        v[`VC_STATE_HALT_BIT] = st.halted;
        v[`VC_STATE_MFI_LSB +: MW] = st.rd_mfi;
      end
      `VC_OFF_BW: v = group_bw;
      default: return {1'b0, 32'h0000_0000};
    endcase
    return {1'b1, v};
  endfunction : reg_read

  // bandwidth in kbit/s, one member rate per step
  assign group_bw = 32'(st.cfg_members) * 32'(member_rate(st.cfg_type));

  assign wr_go = awvalid && wvalid && !st.bvalid;
  assign ar_go = arvalid && !st.rvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = ar_go;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign wr_cur = reg_read(awaddr);
  assign rd_cur = reg_read(araddr);
  assign wd = merge_strb(wr_cur[31:0], wdata, wstrb);

  assign tx_in_ready = st.active && (!st.tx_valid || tx_out_ready);
  assign tx_take = tx_in_valid && tx_in_ready;
  assign tx_last = IW'(st.cfg_members - CW'(1));
  assign tx_out_valid = st.tx_valid;
  assign tx_out_data = st.tx_data;
  assign tx_out_seq = st.tx_seq;
  assign tx_out_container = st.tx_container;
  assign tx_out_mfi = st.tx_mfi;

  // members may arrive in any order, skew bounded by the setting, capped at DEPTH - 1 frames
  assign rx_take = rx_in_valid && st.active && !st.halted;
  assign diff = rx_in_mfi - st.rd_mfi;
  assign bad_seq = rx_take && (CW'(rx_in_seq) >= st.cfg_members);
  assign late = rx_take && !bad_seq && (8'(diff) > st.cfg_maxdly);
  assign buf_wr = rx_take && !bad_seq && !late;
  assign rd_last = IW'(st.cfg_members - CW'(1));
  assign clr_en = (st.rx_state == vcat_pkg::rx_drain) &&
                  (!st.out_valid || rx_out_ready) && (st.rd_idx == rd_last);
  assign rx_out_valid = st.out_valid;
  assign rx_out_data = st.out_data;
  assign group_halted = st.halted;
  assign irq = |(st.irq_status & st.irq_en);
  assign set_mask = {clr_en, bad_seq, late};
  assign flush = wr_go && (awaddr == `VC_OFF_CTRL) &&
                 wd[`VC_CTRL_EN_BIT] && !st.active;

  member_align_buffer #(
    .MAX_MEMBERS(MAX_MEMBERS),
    .DEPTH(DEPTH),
    .IW(IW),
    .CW(CW),
    .SW(SW)
  ) u_align (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(flush),
    .wr_en(buf_wr),
    .wr_slot(rx_in_mfi[SW-1:0]),
    .wr_idx(rx_in_seq),
    .wr_data(rx_in_data),
    .clr_en(clr_en),
    .clr_slot(st.rd_mfi[SW-1:0]),
    .rd_slot(st.rd_mfi[SW-1:0]),
    .rd_idx(st.rd_idx),
    .rd_data(buf_rd_data),
    .slot_count(slot_count)
  );

  always_comb begin
    n = st;
    // register write
    if (st.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp = wr_cur[32] ? `VC_RESP_OKAY : `VC_RESP_SLVERR;
      case (awaddr)
        `VC_OFF_CTRL: begin
          n.sw_enable = wd[`VC_CTRL_EN_BIT];
          n.sw_type = wd[`VC_CTRL_TYPE_LSB +: 3];
        end
        `VC_OFF_MEMBERS: n.sw_members = wd[CW-1:0];
        `VC_OFF_MAXDLY: n.sw_maxdly = wd[7:0];
        `VC_OFF_MAPIDX: n.map_idx = wd[IW-1:0];
        `VC_OFF_MAPVAL: begin
          n.map[st.map_idx] = wd[7:0];
          n.map_idx = st.map_idx + IW'(1);
        end
        `VC_OFF_IRQ_EN: n.irq_en = wd[`VC_IRQ_W-1:0];
        default: ;
      endcase
    end
    // group creation latches type, size and skew setting
    if (flush) begin
      n.active = 1'b1;
      n.halted = 1'b0;
      n.cfg_type = (n.sw_type > 3'h5) ? vcat_pkg::mt_vc12 :
                   vcat_pkg::member_type_t'(n.sw_type);
      n.cfg_members = n.sw_members;
      if (n.sw_members > member_limit(n.cfg_type)) begin
        n.cfg_members = member_limit(n.cfg_type);
      end
      if (n.sw_members == '0) begin
        n.cfg_members = CW'(1);
      end
      n.cfg_maxdly = (n.sw_maxdly > 8'(DEPTH - 1)) ?
                     8'(DEPTH - 1) : n.sw_maxdly;
      n.tx_idx = '0;
      n.tx_frame = '0;
      n.rd_mfi = '0;
      n.rd_idx = '0;
      n.rx_state = vcat_pkg::rx_idle;
    end else if (!n.sw_enable) begin
      n.active = 1'b0;
    end
    // sticky status, a new event beats a clear in the same cycle
    n.irq_status = st.irq_status | set_mask;
    if (wr_go && awaddr == `VC_OFF_IRQ_CLR) begin
      n.irq_status = (st.irq_status & ~wd[`VC_IRQ_W-1:0]) | set_mask;
    end
    // register read
    if (st.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (ar_go) begin
      n.rvalid = 1'b1;
      n.rdata = rd_cur[31:0];
      n.rresp = rd_cur[32] ? `VC_RESP_OKAY : `VC_RESP_SLVERR;
    end
    // source split and tagging
    if (st.tx_valid && tx_out_ready) begin
      n.tx_valid = 1'b0;
    end
    if (tx_take) begin
      n.tx_valid = 1'b1;
      n.tx_data = tx_in_data;
      n.tx_seq = st.tx_idx;
      n.tx_container = st.map[st.tx_idx];
      n.tx_mfi = st.tx_frame;
      if (st.tx_idx == tx_last) begin
        n.tx_idx = '0;
        n.tx_frame = st.tx_frame + MW'(1);
      end else begin
        n.tx_idx = st.tx_idx + IW'(1);
      end
    end
    // sink skew supervision
    if (late) begin
      n.halted = 1'b1;
    end
    // sink alignment and reassembly
    if (st.out_valid && rx_out_ready) begin
      n.out_valid = 1'b0;
    end
    unique case (st.rx_state)
      vcat_pkg::rx_idle: begin
        if (st.active && !st.halted && slot_count == st.cfg_members) begin
          n.rx_state = vcat_pkg::rx_drain;
          n.rd_idx = '0;
        end
      end
      vcat_pkg::rx_drain: begin
        if (!st.out_valid || rx_out_ready) begin
          n.out_valid = 1'b1;
          n.out_data = buf_rd_data;
          if (clr_en) begin
            n.rx_state = vcat_pkg::rx_idle;
            n.rd_mfi = st.rd_mfi + MW'(1);
            n.rd_idx = '0;
          end else begin
            n.rd_idx = st.rd_idx + IW'(1);
          end
        end
      end
    endcase
    if (flush) begin
      n.rx_state = vcat_pkg::rx_idle;
      n.rd_mfi = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.sw_type <= `VC_RST_TYPE;
      st.sw_members <= CW'(`VC_RST_MEMBERS);
      st.sw_maxdly <= `VC_RST_MAXDLY;
      st.cfg_type <= vcat_pkg::mt_vc12;
      st.cfg_members <= CW'(`VC_RST_MEMBERS);
      st.cfg_maxdly <= `VC_RST_MAXDLY;
    end else begin
      st <= n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_idle_no_take: assert property (
    !st.active |-> !tx_in_ready)
    else $error("payload taken while no group exists");

  a_container_map: assert property (
    tx_take |=> tx_out_container == $past(st.map[st.tx_idx]))
    else $error("member stream not placed in its container");

  a_split_rr: assert property (
    tx_take && st.tx_idx != tx_last && !flush |=>
      st.tx_idx == $past(st.tx_idx) + IW'(1) && tx_out_seq == $past(st.tx_idx))
    else $error("payload not split round robin");

  a_frame_step: assert property (
    tx_take && st.tx_idx == tx_last && !flush |=>
      st.tx_frame == $past(st.tx_frame) + MW'(1) && st.tx_idx == '0)
    else $error("frame indicator did not advance after last member");

  a_drain_full: assert property (
    st.rx_state == vcat_pkg::rx_idle ##1 st.rx_state == vcat_pkg::rx_drain
      |-> $past(slot_count) == $past(st.cfg_members))
    else $error("reassembly started before all members aligned");

  a_write_in_window: assert property (
    buf_wr |-> 8'(diff) <= st.cfg_maxdly && st.cfg_maxdly < 8'(DEPTH))
    else $error("member stored beyond the compensated delay");

  a_late_halts: assert property (
    late && !flush |=> st.halted && st.irq_status[`VC_IRQ_DELAY])
    else $error("excess delay did not halt the group");

  a_halt_blocks: assert property (
    st.halted && st.rx_state == vcat_pkg::rx_idle && !flush |=>
      st.rx_state == vcat_pkg::rx_idle [*1] ##1 !$rose(st.out_valid))
    else $error("halted group kept reassembling");

  a_member_limit: assert property (
    st.active |-> st.cfg_members <= member_limit(st.cfg_type) &&
      st.cfg_members != '0)
    else $error("group larger than its member type allows");

  a_write_resp: assert property (
    wr_go |=> st.bvalid)
    else $error("write not answered next cycle");

endmodule : virtual_concat_inverse_mux

// File: core/vcat_regs.svh
/*
  register offsets, field positions, reset values and rate constants
  of the concatenation group end point.
  assumes a 32-bit axi4-lite slave with 8-bit byte addresses.
*/
// Function
// - source splits payload round robin into member streams
// - member type and count are latched from configuration at creation
// - each member stream is tagged with its configured container
// - every member carries a frame indicator so the sink measures skew
// - every member carries its sequence number for order restoration
// - sink accepts members in any order and with independent delay
// - sink waits until all members of a frame arrived, then reassembles
// - sink buffers member data deep enough for the largest expected delay
// - largest compensated differential delay is a software setting, capped at DEPTH - 1 frames
// - up to 64 low-order or 256 high-order members per group
// - group bandwidth is member count times one member payload rate
`ifndef VCAT_REGS_SVH
`define VCAT_REGS_SVH

`define VC_ADDR_W 8
`define VC_OFF_CTRL 8'h00
`define VC_OFF_MEMBERS 8'h04
`define VC_OFF_MAXDLY 8'h08
`define VC_OFF_MAPIDX 8'h0c
`define VC_OFF_MAPVAL 8'h10
`define VC_OFF_IRQ_STATUS 8'h14
`define VC_OFF_IRQ_EN 8'h18
`define VC_OFF_IRQ_CLR 8'h1c
`define VC_OFF_STATE 8'h20
`define VC_OFF_BW 8'h24

`define VC_CTRL_EN_BIT 0
`define VC_CTRL_TYPE_LSB 4
`define VC_STATE_ACTIVE_BIT 0
`define VC_STATE_HALT_BIT 1
`define VC_STATE_MFI_LSB 8

`define VC_RST_TYPE 3'h1
`define VC_RST_MEMBERS 9'h001
`define VC_RST_MAXDLY 8'h03

`define VC_IRQ_W 3
`define VC_IRQ_DELAY 0
`define VC_IRQ_SEQ 1
`define VC_IRQ_ALIGN 2

`define VC_RATE_VC11 18'h00640
`define VC_RATE_VC12 18'h00880
`define VC_RATE_VT3 18'h00d00
`define VC_RATE_VC2 18'h01a80
`define VC_RATE_VC3 18'h0bd00
`define VC_RATE_VC4 18'h24900

`define VC_LIMIT_LO 9'h040
`define VC_LIMIT_HO 9'h100
`define VC_MAX_MEMBERS 256
`define VC_DEPTH 8
`define VC_MFI_W 8

`define VC_RESP_OKAY 2'h0
`define VC_RESP_SLVERR 2'h2

`endif

// File: core/vcat_pkg.sv
/*
  types shared by the concatenation group end point.
  assumes the constants of vcat_regs.svh.
*/
package vcat_pkg;

  typedef enum logic [2:0] {
    mt_vc11,
    mt_vc12,
    mt_vt3,
    mt_vc2,
    mt_vc3,
    mt_vc4
  } member_type_t;

  typedef enum logic [0:0] {
    rx_idle,
    rx_drain
  } rx_state_t;

endpackage : vcat_pkg

// File: core/member_align_buffer.sv
/*
  sink buffer: one byte per member per frame slot, with valid bits
  and a per-slot arrival count.
  assumes the writer never targets a slot beyond the allowed delay.
*/
`timescale 1ns/100ps
`include "vcat_regs.svh"

module member_align_buffer #(
  parameter int MAX_MEMBERS = `VC_MAX_MEMBERS,
  parameter int DEPTH = `VC_DEPTH,
  parameter int IW = $clog2(MAX_MEMBERS),
  parameter int CW = $clog2(MAX_MEMBERS + 1),
  parameter int SW = $clog2(DEPTH)
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic flush,
  input wire logic wr_en,
  input wire logic [SW-1:0] wr_slot,
  input wire logic [IW-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic clr_en,
  input wire logic [SW-1:0] clr_slot,
  // read side
  input wire logic [SW-1:0] rd_slot,
  input wire logic [IW-1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [CW-1:0] slot_count
);
  localparam int E = DEPTH * MAX_MEMBERS;
  localparam int AW = $clog2(E);

  typedef struct packed {
    logic [E-1:0][7:0] data;
    logic [E-1:0] valid;
    logic [DEPTH-1:0][CW-1:0] cnt;
  } buf_t;

  buf_t st;
  buf_t n;
  logic [AW-1:0] wa;

  function automatic logic [AW-1:0] addr(input logic [SW-1:0] s,
                                         input logic [IW-1:0] i);
    return AW'(int'(s) * MAX_MEMBERS + int'(i));
  endfunction : addr

  assign wa = addr(wr_slot, wr_idx);
  assign rd_data = st.data[addr(rd_slot, rd_idx)];
  assign slot_count = st.cnt[rd_slot];

  always_comb begin
    n = st;
    // duplicates are dropped so the count stays honest
    if (wr_en && !st.valid[wa]) begin
      n.data[wa] = wr_data;
      n.valid[wa] = 1'b1;
      n.cnt[wr_slot] = st.cnt[wr_slot] + CW'(1);
    end
    if (clr_en) begin
      n.cnt[clr_slot] = '0;
      for (int i = 0; i < MAX_MEMBERS; i++) begin
        n.valid[addr(clr_slot, IW'(i))] = 1'b0;
      end
    end
    if (flush) begin
      n.valid = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_clear_empties: assert property (
    clr_en && !flush && !(wr_en && wr_slot == clr_slot) |=>
      st.cnt[$past(clr_slot)] == '0)
    else $error("cleared slot still counts entries");

endmodule : member_align_buffer

// File: verif/far_end_model.sv
/*
  peer end point model: loops member bytes back to the sink with the
  member order of each frame reversed; can inject one member byte.
  assumes source and sink share aclk.
*/
`timescale 1ns/100ps

module far_end_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // member streams from the source
  input wire logic [7:0] tx_out_data,
  input wire logic [7:0] tx_out_seq,
  input wire logic [7:0] tx_out_container,
  input wire logic [7:0] tx_out_mfi,
  input wire logic tx_out_valid,
  output logic tx_out_ready,
  // member streams to the sink
  output logic [7:0] rx_in_data,
  output logic [7:0] rx_in_seq,
  output logic [7:0] rx_in_mfi,
  output logic rx_in_valid,
  // bench control
  input wire logic [8:0] members,
  input wire logic slow,
  input wire logic inj_valid,
  input wire logic [7:0] inj_seq,
  input wire logic [7:0] inj_mfi
);
  logic [23:0] frame [$];
  logic [23:0] replay [$];
  logic [31:0] log_q [$];
  logic [23:0] w;

  always @(posedge aclk) begin
    if (!aresetn) begin
      frame = {};
      replay = {};
      tx_out_ready <= 1'b0;
      rx_in_valid <= 1'b0;
      {rx_in_data, rx_in_seq, rx_in_mfi} <= 24'h0;
    end else begin
      tx_out_ready <= !slow || !tx_out_ready;
      if (tx_out_valid && tx_out_ready) begin
        log_q.push_back({tx_out_data, tx_out_seq, tx_out_container,
                         tx_out_mfi});
        frame.push_front({tx_out_data, tx_out_seq, tx_out_mfi});
        if (frame.size() == members) begin
          replay = {replay, frame};
          frame = {};
        end
      end
      if (inj_valid || replay.size() > 0) begin
        if (inj_valid)
          w = {8'h5a, inj_seq, inj_mfi};
        else
          w = replay.pop_front();
        {rx_in_data, rx_in_seq, rx_in_mfi} <= w;
        rx_in_valid <= 1'b1;
      end else begin
        // released lines never hold the last value
        {rx_in_data, rx_in_seq, rx_in_mfi} <=
          ~{rx_in_data, rx_in_seq, rx_in_mfi};
        rx_in_valid <= 1'b0;
      end
    end
  end
endmodule : far_end_model

// File: verif/virtual_concat_inverse_mux_tb.sv
/*
  self-checking bench of the concatenation group end point.
  assumes the far end model loops source members back to the sink.
*/
`timescale 1ns/100ps
`include "vcat_regs.svh"

module virtual_concat_inverse_mux_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tx_in_valid, tx_in_ready;
  logic tx_out_valid, tx_out_ready, rx_in_valid, rx_out_valid;
  logic rx_out_ready, group_halted, irq, slow, inj_valid;
  logic [7:0] awaddr, araddr, tx_in_data, tx_out_data, tx_out_seq;
  logic [7:0] tx_out_container, tx_out_mfi, rx_in_data, rx_in_seq;
  logic [7:0] rx_in_mfi, rx_out_data, inj_seq, inj_mfi;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [8:0] members;
  int failures, checks;

  virtual_concat_inverse_mux i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .tx_in_data(tx_in_data),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_out_data(tx_out_data), .tx_out_seq(tx_out_seq),
    .tx_out_container(tx_out_container), .tx_out_mfi(tx_out_mfi),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .rx_in_data(rx_in_data), .rx_in_seq(rx_in_seq),
    .rx_in_mfi(rx_in_mfi), .rx_in_valid(rx_in_valid),
    .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .group_halted(group_halted), .irq(irq));

  far_end_model i_far (
    .aclk(aclk), .aresetn(aresetn), .tx_out_data(tx_out_data),
    .tx_out_seq(tx_out_seq), .tx_out_container(tx_out_container),
    .tx_out_mfi(tx_out_mfi), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .rx_in_data(rx_in_data),
    .rx_in_seq(rx_in_seq), .rx_in_mfi(rx_in_mfi),
    .rx_in_valid(rx_in_valid), .members(members), .slow(slow),
    .inj_valid(inj_valid), .inj_seq(inj_seq), .inj_mfi(inj_mfi));

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // unmapped offsets answer with slave error
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    chk("bresp", (a > 8'h24) ? 32'h2 : 32'h0, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk($sformatf("rdata %h", a), e, rdata);
    chk("rresp", (a > 8'h24) ? 32'h2 : 32'h0, {30'h0, rresp});
  endtask : rd

  task automatic create(input logic [2:0] t, input logic [8:0] m);
    wr(`VC_OFF_CTRL, 32'h0);
    wr(`VC_OFF_MEMBERS, {23'h0, m});
    wr(`VC_OFF_CTRL, {25'h0, t, 4'h1});
  endtask : create

  task automatic inject(input logic [7:0] s, input logic [7:0] m);
    inj_seq <= s;
    inj_mfi <= m;
    inj_valid <= 1'b1;
    @(posedge aclk);
    inj_valid <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : inject

  task automatic irq_is(input logic e);
    @(negedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge aclk);
  endtask : irq_is

  task automatic t_reset;
    @(negedge aclk);
    chk("tx_in_ready", 32'h0, {31'h0, tx_in_ready});
    @(posedge aclk);
    rd(`VC_OFF_CTRL, 32'h10);
    rd(`VC_OFF_MEMBERS, 32'h1);
    rd(`VC_OFF_MAXDLY, 32'h3);
    rd(`VC_OFF_IRQ_EN, 32'h0);
    rd(`VC_OFF_STATE, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'hffff_ffff);
  endtask : t_reset

  task automatic t_rates;
    logic [31:0] r [8] = '{1600, 2176, 3328, 6784, 48384, 149760,
                           2176, 2176};
    for (int c = 0; c < 8; c++) begin
      create(3'(c), 9'h001);
      rd(`VC_OFF_BW, r[c]);
    end
    create(3'h0, 9'h064);
    rd(`VC_OFF_BW, 32'd102400);
    create(3'h5, 9'h12c);
    rd(`VC_OFF_BW, 32'd38338560);
    create(3'h3, 9'h000);
    rd(`VC_OFF_BW, 32'd6784);
  endtask : t_rates

  task automatic t_split;
    int n;
    members <= 9'h003;
    slow <= 1'b1;
    wr(`VC_OFF_MAPIDX, 32'h0);
    for (int k = 0; k < 3; k++)
      wr(`VC_OFF_MAPVAL, 32'ha0 + 32'(k));
    wr(`VC_OFF_MAPIDX, 32'h1);
    rd(`VC_OFF_MAPVAL, 32'ha1);
    wr(`VC_OFF_IRQ_EN, 32'h7);
    create(3'h1, 9'h003);
    rd(`VC_OFF_STATE, 32'h1);
    fork
      for (int k = 0; k < 6; k++) begin
        n = 0;
        tx_in_data <= 8'h30 + 8'(k);
        tx_in_valid <= 1'b1;
        do @(posedge aclk); while (!tx_in_ready && ++n < 50);
        if (k == 5)
          tx_in_valid <= 1'b0;
      end
      for (int k = 0; k < 6; k++) begin
        int m;
        m = 0;
        do @(posedge aclk); while (!rx_out_valid && ++m < 300);
        chk("rx_out", 32'h30 + 32'(k), {24'h0, rx_out_data});
      end
    join
    for (int k = 0; k < 6; k++)
      chk("member", {8'(8'h30 + k), 8'(k % 3), 8'(8'ha0 + k % 3),
          8'(k / 3)}, i_far.log_q[k]);
    rd(`VC_OFF_STATE, 32'h201);
    rd(`VC_OFF_IRQ_STATUS, 32'h4);
    irq_is(1'b1);
    wr(`VC_OFF_IRQ_EN, 32'h3);
    irq_is(1'b0);
    wr(`VC_OFF_IRQ_CLR, 32'h4);
    rd(`VC_OFF_IRQ_STATUS, 32'h0);
  endtask : t_split

  task automatic t_faults;
    inject(8'h05, 8'h02);
    rd(`VC_OFF_IRQ_STATUS, 32'h2);
    inject(8'h00, 8'h05);
    rd(`VC_OFF_STATE, 32'h201);
    inject(8'h00, 8'h06);
    rd(`VC_OFF_IRQ_STATUS, 32'h3);
    rd(`VC_OFF_STATE, 32'h203);
    chk("halted", 32'h1, {31'h0, group_halted});
    irq_is(1'b1);
    wr(`VC_OFF_IRQ_CLR, 32'h3);
    create(3'h1, 9'h003);
    rd(`VC_OFF_IRQ_STATUS, 32'h0);
    rd(`VC_OFF_STATE, 32'h1);
    chk("halted", 32'h0, {31'h0, group_halted});
    wr(`VC_OFF_MAXDLY, 32'h20);
    rd(`VC_OFF_MAXDLY, 32'h20);
    create(3'h1, 9'h003);
    inject(8'h00, 8'h07);
    rd(`VC_OFF_STATE, 32'h1);
    inject(8'h00, 8'h08);
    rd(`VC_OFF_STATE, 32'h3);
  endtask : t_faults

  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    results();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, tx_in_data, inj_seq, inj_mfi} = 40'h0;
    {awprot, arprot, wdata} = 38'h0;
    {tx_in_valid, slow, inj_valid} = 3'h0;
    wstrb = 4'hf;
    rx_out_ready = 1'b1;
    members = 9'h001;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_rates();
    t_split();
    t_faults();
    results();
  end
endmodule : virtual_concat_inverse_mux_tb
